// *** modbus_slave_regs.vh ***
/*
  Constants for the serial service and Modbus slave port block:
  baud codes and rates, line, stop and parity codes, register and
  coil addresses, reset values and the scaling of node inputs.
  Assumes a 100 MHz system clock.
*/
`ifndef MODBUS_SLAVE_REGS_VH
`define MODBUS_SLAVE_REGS_VH

// System clock and oversampling of the serial engines
`define CLK_HZ       100000000
`define OVERSAMPLE   16

// Baud codes, shared by both ports
`define BAUD_100     4'h0
`define BAUD_300     4'h1
`define BAUD_600     4'h2
`define BAUD_1200    4'h3
`define BAUD_1800    4'h4
`define BAUD_2400    4'h5
`define BAUD_4800    4'h6
`define BAUD_9600    4'h7
`define BAUD_19200   4'h8
`define BAUD_38400   4'h9

// Baud rates in bits per second
`define HZ_100       100
`define HZ_300       300
`define HZ_600       600
`define HZ_1200      1200
`define HZ_1800      1800
`define HZ_2400      2400
`define HZ_4800      4800
`define HZ_9600      9600
`define HZ_19200     19200
`define HZ_38400     38400

// Line standards, stop bits, parity
`define LINE_RS232   2'h0
`define LINE_RS422   2'h1
`define LINE_RS485   2'h2
`define STOP_1       2'h0
`define STOP_1P5     2'h1
`define STOP_2       2'h2
`define PAR_NONE     2'h0
`define PAR_ODD      2'h1
`define PAR_EVEN     2'h2

// Analog write addresses
`define AW_AO1       16'h0002
`define AW_AO2       16'h0003
`define AW_AO4       16'h0004
`define AW_SPEED     16'h0005

// Groups of eight addresses (address bits 15:3), then single addresses and node counts
`define BG_CMD       13'h0000
`define BG_USE       13'h0001
`define BG_RELAY     13'h0004
`define RG_NODE_AO   13'h0002
`define RG_NODE_AI   13'h000A
`define BA_ALARM     16'h0010
`define AR_CFG       16'h0040
`define AR_STATUS    16'h0041
`define NODE_N       3'h6
`define NODE_LAST    3'h5

// Node input full scale in microamps for a 12-bit code
`define AI_FULL_UA   15'd25000

// Reset values
`define RST_BAUD     4'h7

`endif

// *** baud_tick_gen.v ***
/*
  Oversampling tick generator for one serial port.
  Assumes baud_sel comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "modbus_slave_regs.vh"

module baud_tick_gen (
  input  wire       clock,
  input  wire       rst_n,
  input  wire [3:0] baud_sel,
  output reg        tick_ff
);

  reg  [16:0] cnt_ff;
  reg  [31:0] div_full;
  wire [16:0] div_last;

  // Cycles per oversample tick for the selected rate
  always @* begin
    case (baud_sel)
      `BAUD_100:   div_full = `CLK_HZ / (`OVERSAMPLE * `HZ_100);
      `BAUD_300:   div_full = `CLK_HZ / (`OVERSAMPLE * `HZ_300);
      `BAUD_600:   div_full = `CLK_HZ / (`OVERSAMPLE * `HZ_600);
      `BAUD_1200:  div_full = `CLK_HZ / (`OVERSAMPLE * `HZ_1200);
      `BAUD_1800:  div_full = `CLK_HZ / (`OVERSAMPLE * `HZ_1800);
      `BAUD_2400:  div_full = `CLK_HZ / (`OVERSAMPLE * `HZ_2400);
      `BAUD_4800:  div_full = `CLK_HZ / (`OVERSAMPLE * `HZ_4800);
      `BAUD_19200: div_full = `CLK_HZ / (`OVERSAMPLE * `HZ_19200);
      `BAUD_38400: div_full = `CLK_HZ / (`OVERSAMPLE * `HZ_38400);
      default:     div_full = `CLK_HZ / (`OVERSAMPLE * `HZ_9600);
    endcase
  end

  assign div_last = div_full[16:0] - 17'h00001;

  // Free-running divider; a shrinking divisor wraps at once
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= 17'h00000;
      tick_ff <= 1'b0;
    end else if (cnt_ff >= div_last) begin
      cnt_ff  <= 17'h00000;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 17'h00001;
      tick_ff <= 1'b0;
    end
  end

endmodule // baud_tick_gen

`default_nettype wire

// *** node_out_mem.v ***
/*
  Eight-word store of remote node analog output values.
  One write port, one read port with registered data.
*/
`timescale 1ns/1ps
`default_nettype none

module node_out_mem (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        wr_en,
  input  wire [2:0]  wr_addr,
  input  wire [15:0] wr_data,
  input  wire [2:0]  rd_addr,
  output reg  [15:0] rd_data_ff
);

  reg [15:0] mem [0:7];

  // Storage array, no reset
  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 16'h0000;
    end else begin
      rd_data_ff <= mem[rd_addr];
    end
  end

endmodule // node_out_mem

`default_nettype wire

// *** modbus_slave_port_control.v ***
/*
  Serial service and Modbus slave port control: port configuration,
  baud ticks, decoded Modbus requests, remote discrete command
  gating, analog write targets and remote node value scaling.
  Assumes requests arrive already decoded from the serial engines
  on the same clock; discrete pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "modbus_slave_regs.vh"

// ****************************************************************
// ****************************************************************

module modbus_slave_port_control (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        cfg_wr,
  input  wire        cfg_sel_modbus,
  input  wire [3:0]  cfg_baud,
  input  wire [1:0]  cfg_line,
  input  wire [1:0]  cfg_stop,
  input  wire [1:0]  cfg_parity,
  input  wire        cfg_ascii,
  output reg         cfg_done_ff,
  output reg         cfg_reject_ff,
  output reg         svc_rs422_ff,
  output wire        svc_baud_tick_ff,
  output reg  [1:0]  mb_line_ff,
  output reg  [1:0]  mb_stop_ff,
  output reg  [1:0]  mb_parity_ff,
  output reg         mb_ascii_ff,
  output wire        mb_baud_tick_ff,
  input  wire        req_valid,
  input  wire        req_from_modbus,
  input  wire        req_write,
  input  wire        req_bool,
  input  wire [15:0] req_addr,
  input  wire [15:0] req_wdata,
  output reg         req_ready_ff,
  output reg         resp_valid_ff,
  output reg         resp_err_ff,
  output reg  [15:0] resp_data_ff,
  input  wire [7:0]  hw_di,
  input  wire        hw_alarm_reset,
  input  wire        sw_alarm_reset,
  output reg  [7:0]  func_active_ff,
  output reg         alarm_reset_ff,
  output reg  [15:0] ao1_source_ff,
  output reg  [15:0] ao2_source_ff,
  output reg  [15:0] ao4_source_ff,
  output reg  [15:0] speed_ref_rpm_ff,
  output reg  [7:0]  relay_drive_ff,
  output reg  [2:0]  node_ao_idx_ff,
  output reg  [15:0] node_ao_value_ff,
  output reg  [2:0]  node_ai_sel_ff,
  input  wire [11:0] node_ai_code
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam ST_IDLE  = 2'h0;
  localparam ST_ISSUE = 2'h1;
  localparam ST_CALC  = 2'h2;
  localparam ST_ANS   = 2'h3;

  reg  [7:0]  di_meta_ff;
  reg  [7:0]  di_sync_ff;
  reg         alarm_meta_ff;
  reg         alarm_sync_ff;
  reg  [3:0]  svc_baud_ff;
  reg  [3:0]  mb_baud_ff;
  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg         rq_mb_ff;
  reg         rq_wr_ff;
  reg         rq_bool_ff;
  reg  [15:0] rq_addr_ff;
  reg  [15:0] rq_data_ff;
  reg  [7:0]  cmd_ff;
  reg  [7:0]  use_remote_ff;
  reg         mb_alarm_ff;
  reg  [5:0]  node_written_ff;
  reg  [2:0]  scan_idx_ff;
  reg  [2:0]  scan_idx_d_ff;
  reg  [15:0] nxt_resp_data;
  wire [15:0] mem_rd_data;
  wire        svc_ok;
  wire        mb_ok;
  wire        cfg_ok;
  wire [2:0]  idx;
  wire        g_cmd;
  wire        g_use;
  wire        g_relay;
  wire        hit_cmd;
  wire        hit_use;
  wire        hit_alarm;
  wire        hit_relay_w;
  wire        hit_di_r;
  wire        hit_relay_r;
  wire        hit_ao1;
  wire        hit_ao2;
  wire        hit_ao4;
  wire        hit_speed;
  wire        hit_node_w;
  wire        hit_node_r;
  wire        hit_cfg_r;
  wire        hit_stat_r;
  wire        any_hit;
  wire        do_write;
  wire [26:0] ai_prod;

  // Baud pairing that the two ports may not share
  function pair_bad;
    input [3:0] svc;
    input [3:0] mb;
    begin
      pair_bad = ((svc == `BAUD_19200) && (mb == `BAUD_38400)) ||
                 ((svc == `BAUD_38400) && (mb == `BAUD_19200));
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Two flops on discrete and alarm reset pins
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      di_meta_ff    <= 8'h00;
      di_sync_ff    <= 8'h00;
      alarm_meta_ff <= 1'b0;
      alarm_sync_ff <= 1'b0;
    end else begin
      di_meta_ff    <= hw_di;
      di_sync_ff    <= di_meta_ff;
      alarm_meta_ff <= hw_alarm_reset;
      alarm_sync_ff <= alarm_meta_ff;
    end
  end

  // ****************************************************************
  // Port configuration
  // ****************************************************************
  // service baud range
  assign svc_ok = (cfg_baud <= `BAUD_38400) &&
                  (cfg_line <= `LINE_RS422) &&
                  !pair_bad(cfg_baud, mb_baud_ff);

  assign mb_ok = (cfg_baud >= `BAUD_1200) &&
                 (cfg_baud <= `BAUD_38400) &&
                 (cfg_line <= `LINE_RS485) &&
                 (cfg_stop <= `STOP_2) &&
                 (cfg_parity <= `PAR_EVEN) &&
                 !pair_bad(svc_baud_ff, cfg_baud);

  assign cfg_ok = cfg_sel_modbus ? mb_ok : svc_ok;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      svc_baud_ff   <= `RST_BAUD;
      mb_baud_ff    <= `RST_BAUD;
      svc_rs422_ff  <= 1'b0;
      mb_line_ff    <= `LINE_RS232;
      mb_stop_ff    <= `STOP_1;
      mb_parity_ff  <= `PAR_NONE;
      mb_ascii_ff   <= 1'b0;
      cfg_done_ff   <= 1'b0;
      cfg_reject_ff <= 1'b0;
    end else begin
      cfg_done_ff   <= cfg_wr & cfg_ok;
      cfg_reject_ff <= cfg_wr & ~cfg_ok;
      if (cfg_wr && cfg_ok && !cfg_sel_modbus) begin
        svc_baud_ff  <= cfg_baud;
        svc_rs422_ff <= (cfg_line == `LINE_RS422);
      end
      if (cfg_wr && cfg_ok && cfg_sel_modbus) begin
        mb_baud_ff   <= cfg_baud;
        mb_line_ff   <= cfg_line;
        mb_stop_ff   <= cfg_stop;
        mb_parity_ff <= cfg_parity;
        mb_ascii_ff  <= cfg_ascii;
      end
    end
  end

  // Oversample ticks for the two serial engines
  baud_tick_gen u_svc_baud (
    .clock    (clock),
    .rst_n    (rst_n),
    .baud_sel (svc_baud_ff),
    .tick_ff  (svc_baud_tick_ff)
  );

  baud_tick_gen u_mb_baud (
    .clock    (clock),
    .rst_n    (rst_n),
    .baud_sel (mb_baud_ff),
    .tick_ff  (mb_baud_tick_ff)
  );

  // ****************************************************************
  // Request decode
  // ****************************************************************
  // Address hits on the latched request
  assign idx         = rq_addr_ff[2:0];
  assign g_cmd       = (rq_addr_ff[15:3] == `BG_CMD);
  assign g_use       = (rq_addr_ff[15:3] == `BG_USE);
  assign g_relay     = (rq_addr_ff[15:3] == `BG_RELAY);
  assign hit_cmd     = rq_bool_ff & rq_wr_ff & g_cmd;
  assign hit_use     = rq_bool_ff & rq_wr_ff & g_use;
  assign hit_alarm   = rq_bool_ff & rq_wr_ff & (rq_addr_ff == `BA_ALARM);
  assign hit_relay_w = rq_bool_ff & rq_wr_ff & g_relay & rq_mb_ff;
  assign hit_node_w  = ~rq_bool_ff & rq_wr_ff & rq_mb_ff & (idx <= `NODE_LAST) &
                       (rq_addr_ff[15:3] == `RG_NODE_AO);
  assign hit_di_r    = rq_bool_ff & ~rq_wr_ff & g_cmd;
  assign hit_relay_r = rq_bool_ff & ~rq_wr_ff & g_relay;
  assign hit_ao1     = ~rq_bool_ff & rq_wr_ff & (rq_addr_ff == `AW_AO1);
  assign hit_ao2     = ~rq_bool_ff & rq_wr_ff & (rq_addr_ff == `AW_AO2);
  assign hit_ao4     = ~rq_bool_ff & rq_wr_ff & (rq_addr_ff == `AW_AO4);
  assign hit_speed   = ~rq_bool_ff & rq_wr_ff & (rq_addr_ff == `AW_SPEED);
  assign hit_node_r  = ~rq_bool_ff & ~rq_wr_ff & (idx <= `NODE_LAST) &
                       (rq_addr_ff[15:3] == `RG_NODE_AI);
  assign hit_cfg_r   = ~rq_bool_ff & ~rq_wr_ff & (rq_addr_ff == `AR_CFG);
  assign hit_stat_r  = ~rq_bool_ff & ~rq_wr_ff & (rq_addr_ff == `AR_STATUS);
  assign any_hit     = hit_cmd | hit_use | hit_alarm | hit_relay_w |
                       hit_node_w | hit_di_r | hit_relay_r | hit_ao1 |
                       hit_ao2 | hit_ao4 | hit_speed | hit_node_r |
                       hit_cfg_r | hit_stat_r;
  assign do_write    = (state_ff == ST_ISSUE);

  assign ai_prod = node_ai_code * `AI_FULL_UA;

  // Answer data for the latched request
  always @* begin
    nxt_resp_data = 16'h0000;
    if (hit_di_r) begin
      nxt_resp_data = {15'h0000, di_sync_ff[idx]};
    end else if (hit_relay_r) begin
      nxt_resp_data = {15'h0000, relay_drive_ff[idx]};
    end else if (hit_node_r) begin
      nxt_resp_data = {1'b0, ai_prod[26:12]};
    end else if (hit_cfg_r) begin
      nxt_resp_data = {mb_ascii_ff, mb_parity_ff, mb_stop_ff, mb_line_ff,
                       svc_rs422_ff, mb_baud_ff, svc_baud_ff};
    end else if (hit_stat_r) begin
      nxt_resp_data = {7'h00, alarm_reset_ff, func_active_ff};
    end
  end

  // ****************************************************************
  // Request sequencer
  // ****************************************************************
  // Take, write, answer, recover
  always @* begin
    case (state_ff)
      ST_IDLE:  nxt_state = req_valid ? ST_ISSUE : ST_IDLE;
      ST_ISSUE: nxt_state = ST_CALC;
      ST_CALC:  nxt_state = ST_ANS;
      ST_ANS:   nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  // State, latched request and answer
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff       <= ST_IDLE;
      req_ready_ff   <= 1'b1;
      rq_mb_ff       <= 1'b0;
      rq_wr_ff       <= 1'b0;
      rq_bool_ff     <= 1'b0;
      rq_addr_ff     <= 16'h0000;
      rq_data_ff     <= 16'h0000;
      node_ai_sel_ff <= 3'h0;
      resp_valid_ff  <= 1'b0;
      resp_err_ff    <= 1'b0;
      resp_data_ff   <= 16'h0000;
    end else begin
      state_ff      <= nxt_state;
      req_ready_ff  <= (nxt_state == ST_IDLE);
      resp_valid_ff <= (state_ff == ST_CALC);
      if (state_ff == ST_IDLE && req_valid) begin
        rq_mb_ff       <= req_from_modbus;
        rq_wr_ff       <= req_write;
        rq_bool_ff     <= req_bool;
        rq_addr_ff     <= req_addr;
        rq_data_ff     <= req_wdata;
        node_ai_sel_ff <= req_addr[2:0];
      end
      if (state_ff == ST_CALC) begin
        resp_err_ff  <= ~any_hit;
        resp_data_ff <= nxt_resp_data;
      end
    end
  end

  // ****************************************************************
  // Command and output registers
  // ****************************************************************
  // Coils and analog targets written on the issue cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff           <= 8'h00;
      use_remote_ff    <= 8'h00;
      mb_alarm_ff      <= 1'b0;
      relay_drive_ff   <= 8'h00;
      ao1_source_ff    <= 16'h0000;
      ao2_source_ff    <= 16'h0000;
      ao4_source_ff    <= 16'h0000;
      speed_ref_rpm_ff <= 16'h0000;
      node_written_ff  <= 6'h00;
    end else if (do_write) begin
      if (hit_cmd) begin
        cmd_ff[idx] <= rq_data_ff[0];
      end
      if (hit_use) begin
        use_remote_ff[idx] <= rq_data_ff[0];
      end
      if (hit_alarm) begin
        mb_alarm_ff <= rq_data_ff[0];
      end
      if (hit_relay_w) begin
        relay_drive_ff[idx] <= rq_data_ff[0];
      end
      if (hit_ao1) begin
        ao1_source_ff <= rq_data_ff;
      end
      if (hit_ao2) begin
        ao2_source_ff <= rq_data_ff;
      end
      if (hit_ao4) begin
        ao4_source_ff <= rq_data_ff;
      end
      if (hit_speed) begin
        speed_ref_rpm_ff <= rq_data_ff;
      end
      if (hit_node_w) begin
        node_written_ff[idx] <= 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_func
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          func_active_ff[g] <= 1'b0;
        end else begin
          func_active_ff[g] <= use_remote_ff[g] ? cmd_ff[g] : di_sync_ff[g];
        end
      end
    end
  endgenerate

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reset_ff <= 1'b0;
    end else begin
      alarm_reset_ff <= alarm_sync_ff | sw_alarm_reset | mb_alarm_ff;
    end
  end

  // ****************************************************************
  // Node analog output scan
  // ****************************************************************
  // Node output store, written only by the Modbus port
  node_out_mem u_node_mem (
    .clock      (clock),
    .rst_n      (rst_n),
    .wr_en      (do_write & hit_node_w),
    .wr_addr    (idx),
    .wr_data    (rq_data_ff),
    .rd_addr    (scan_idx_ff),
    .rd_data_ff (mem_rd_data)
  );

  // Cycle through the six outputs; unwritten ones present zero
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scan_idx_ff      <= 3'h0;
      scan_idx_d_ff    <= 3'h0;
      node_ao_idx_ff   <= 3'h0;
      node_ao_value_ff <= 16'h0000;
    end else begin
      scan_idx_ff      <= (scan_idx_ff == `NODE_LAST) ? 3'h0 : scan_idx_ff + 3'h1;
      scan_idx_d_ff    <= scan_idx_ff;
      node_ao_idx_ff   <= scan_idx_d_ff;
      node_ao_value_ff <= node_written_ff[scan_idx_d_ff] ? mem_rd_data : 16'h0000;
    end
  end

endmodule // modbus_slave_port_control

`default_nettype wire

// *** modbus_slave_port_control_properties.sv ***
/* Checker of port timing and effects for modbus_slave_port_control.
   Assumes it sees the block's top ports only; bound at the foot. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Checker
// ****************************************************************
module modbus_slave_port_control_properties (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        cfg_wr,
  input wire logic        cfg_sel_modbus,
  input wire logic [3:0]  cfg_baud,
  input wire logic [1:0]  cfg_stop,
  input wire logic        cfg_done_ff,
  input wire logic        cfg_reject_ff,
  input wire logic [1:0]  mb_line_ff,
  input wire logic [1:0]  mb_stop_ff,
  input wire logic        req_valid,
  input wire logic        req_ready_ff,
  input wire logic        req_from_modbus,
  input wire logic        req_write,
  input wire logic        req_bool,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic        resp_valid_ff,
  input wire logic        resp_err_ff,
  input wire logic [7:0]  relay_drive_ff,
  input wire logic [15:0] ao1_source_ff,
  input wire logic [15:0] speed_ref_rpm_ff,
  input wire logic        sw_alarm_reset,
  input wire logic        alarm_reset_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Request taken at this edge
  wire logic take = req_valid && req_ready_ff;
  wire logic regw = take && req_write && !req_bool;

  a_cfg_answer_once: assert property (cfg_wr |=> cfg_done_ff ^ cfg_reject_ff) else $error("config answer wrong");
  a_reject_keeps_set: assert property (cfg_reject_ff |-> $stable(mb_line_ff) && $stable(mb_stop_ff)) else $error("rejected config changed settings");
  a_baud_low_refused: assert property (cfg_wr && cfg_sel_modbus && cfg_baud < 4'h3 |=> cfg_reject_ff) else $error("low baud taken");
  a_stop_code_refused: assert property (cfg_wr && cfg_sel_modbus && cfg_stop == 2'h3 |=> cfg_reject_ff) else $error("bad stop taken");
  a_resp_timing_exact: assert property (take |=> !req_ready_ff ##1 !resp_valid_ff ##1 resp_valid_ff ##1 (req_ready_ff && !resp_valid_ff)) else $error("answer timing wrong");
  a_speed_ref_write: assert property (regw && req_addr == 16'h0005 |=> ##1 speed_ref_rpm_ff == $past(req_wdata, 2)) else $error("speed ref not written");
  a_ao1_source_write: assert property (regw && req_addr == 16'h0002 |=> ##1 ao1_source_ff == $past(req_wdata, 2)) else $error("output one not written");
  a_relay_svc_refused: assert property (take && req_write && req_bool && !req_from_modbus && req_addr[15:3] == 13'h0004 |=> ##1 $stable(relay_drive_ff) ##1 resp_err_ff) else $error("service relay write taken");
  a_alarm_or_sw: assert property ($rose(sw_alarm_reset) |-> ##[1:3] alarm_reset_ff) else $error("tool alarm reset lost");

  c_reject: cover property (cfg_reject_ff);
  c_resp_err: cover property (resp_valid_ff && resp_err_ff);
  c_resp_ok: cover property (resp_valid_ff && !resp_err_ff);
endmodule // modbus_slave_port_control_properties

bind modbus_slave_port_control modbus_slave_port_control_properties u_modbus_slave_port_control_properties (.*);
`default_nettype wire

// *** modbus_master_model.sv ***
/* Behavioural Modbus master on the decoded request port.
   Assumes the slave answers on the same clock. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Master model
// ****************************************************************
module modbus_master_model (
  input  wire logic        clock,
  input  wire logic        req_ready_ff,
  input  wire logic        resp_valid_ff,
  input  wire logic        resp_err_ff,
  input  wire logic [15:0] resp_data_ff,
  output var  logic        req_valid,
  output var  logic        req_from_modbus,
  output var  logic        req_write,
  output var  logic        req_bool,
  output var  logic [15:0] req_addr,
  output var  logic [15:0] req_wdata
);
  initial {req_valid, req_from_modbus, req_write, req_bool, req_addr, req_wdata} = 35'h0;
  task automatic xfer(input logic m, w, b, input logic [15:0] a, d, output logic [15:0] rd, output logic er);
    @(negedge clock);
    {req_from_modbus, req_write, req_bool, req_addr, req_wdata, req_valid} = {m, w, b, a, d, 1'b1};
    do @(posedge clock); while (req_ready_ff !== 1'b1);
    @(negedge clock);
    req_valid = 1'b0;
    req_addr = ~a; // Released lines do not keep old value
    req_wdata = ~d;
    for (int i = 0; i < 8 && resp_valid_ff !== 1'b1; i++) @(negedge clock);
    rd = resp_data_ff;
    er = resp_err_ff;
  endtask
endmodule // modbus_master_model
`default_nettype wire

// *** modbus_slave_port_control_tb.sv ***
/* Self-checking bench for modbus_slave_port_control.
   Assumes modbus_master_model drives the request port. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bench
// ****************************************************************
module modbus_slave_port_control_tb;
  localparam logic on = 1'b1;
  localparam logic no = 1'b0;
  logic clock = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_sel_modbus = 1'b0, cfg_ascii = 1'b0;
  logic [3:0] cfg_baud = 4'h7;
  logic [1:0] cfg_line = 2'h0, cfg_stop = 2'h0, cfg_parity = 2'h0;
  logic [7:0] hw_di = 8'h0F;
  logic hw_alarm_reset = 1'b0, sw_alarm_reset = 1'b0, re, seen;
  logic [11:0] node_ai_code = 12'hFFF;
  logic [15:0] rd;
  wire logic req_valid, req_from_modbus, req_write, req_bool, req_ready_ff, resp_valid_ff, resp_err_ff;
  wire logic [15:0] req_addr, req_wdata, resp_data_ff, ao1_source_ff, ao2_source_ff, ao4_source_ff;
  wire logic [15:0] speed_ref_rpm_ff, node_ao_value_ff;
  wire logic cfg_done_ff, cfg_reject_ff, svc_rs422_ff, svc_baud_tick_ff, mb_ascii_ff, mb_baud_tick_ff;
  wire logic alarm_reset_ff;
  wire logic [1:0] mb_line_ff, mb_stop_ff, mb_parity_ff;
  wire logic [7:0] func_active_ff, relay_drive_ff;
  wire logic [2:0] node_ao_idx_ff, node_ai_sel_ff;
  int err_total = 0, tests_run = 0, cyc = 0, n;

  modbus_slave_port_control u_modbus_slave_port_control (.*);
  modbus_master_model u_modbus_master_model (.*);

  // Clock and run limit
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Config write and its answer one cycle later
  task automatic cfg(input logic m, input logic [3:0] b, input logic [1:0] l, s, p, input logic a, rej);
    @(negedge clock);
    {cfg_sel_modbus, cfg_baud, cfg_line, cfg_stop, cfg_parity, cfg_ascii, cfg_wr} = {m, b, l, s, p, a, 1'b1};
    @(negedge clock);
    cfg_wr = 1'b0;
    chk("cfg_ans", {14'h0, rej, !rej}, {14'h0, cfg_reject_ff, cfg_done_ff});
    if (m && !rej) chk("mb_set", {9'h0, a, p, s, l}, {9'h0, mb_ascii_ff, mb_parity_ff, mb_stop_ff, mb_line_ff});
  endtask

  task automatic io(input logic m, w, b, input logic [15:0] a, d, input logic e);
    u_modbus_master_model.xfer(m, w, b, a, d, rd, re);
    chk("resp_err", {15'h0, e}, {15'h0, re});
  endtask

  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    io(on, no, no, 16'h0040, 16'h0000, no); chk("cfg_word", 16'h0077, rd);
    for (int i = 0; i < 3; i++) cfg(on, 4'h3 + 4'(i), 2'(i), 2'(i), 2'(i), i[0], no);
    cfg(on, 4'h2, 2'h0, 2'h0, 2'h0, no, on);
    cfg(on, 4'h7, 2'h0, 2'h3, 2'h0, no, on);
    cfg(on, 4'h7, 2'h3, 2'h0, 2'h0, no, on);
    cfg(on, 4'h7, 2'h0, 2'h0, 2'h3, no, on);
    cfg(on, 4'h7, 2'h0, 2'h0, 2'h0, no, no);
    for (int i = 0; i < 10; i++) begin
      cfg(no, 4'(i), {1'b0, i[0]}, 2'h0, 2'h0, no, no);
      io(on, no, no, 16'h0040, 16'h0000, no); chk("svc_cfg", {7'h0, i[0], 4'h7, 4'(i)}, rd);
    end
    cfg(no, 4'h7, 2'h2, 2'h0, 2'h0, no, on);
    cfg(on, 4'h8, 2'h0, 2'h0, 2'h0, no, on);
    cfg(no, 4'h8, 2'h0, 2'h0, 2'h0, no, no);
    cfg(on, 4'h9, 2'h0, 2'h0, 2'h0, no, on);
    cfg(on, 4'h8, 2'h0, 2'h0, 2'h0, no, no);
    cfg(no, 4'h9, 2'h0, 2'h0, 2'h0, no, on);
    io(on, no, no, 16'h0040, 16'h0000, no); chk("pair_kept", 16'h0088, rd);
    io(no, on, no, 16'h0002, 16'hD120, no); chk("ao1", 16'hD120, ao1_source_ff);
    io(no, on, no, 16'h0003, 16'h2EE0, no); chk("ao2", 16'h2EE0, ao2_source_ff);
    io(no, on, no, 16'h0004, 16'h0FA0, no); chk("ao4", 16'h0FA0, ao4_source_ff);
    io(on, on, no, 16'h0005, 16'h0708, no); chk("speed", 16'h0708, speed_ref_rpm_ff);
    io(on, on, no, 16'h0006, 16'h1234, on);
    io(on, no, no, 16'h0005, 16'h0000, on);
    io(on, on, on, 16'h0021, 16'h0001, no); chk("relay_on", 16'h0002, {8'h0, relay_drive_ff});
    io(no, on, on, 16'h0022, 16'h0001, on); chk("relay_svc", 16'h0002, {8'h0, relay_drive_ff});
    io(on, on, on, 16'h0021, 16'h0000, no); chk("relay_off", 16'h0000, {8'h0, relay_drive_ff});
    io(no, on, no, 16'h0011, 16'h2EE0, on);
    io(on, on, no, 16'h0011, 16'h2EE0, no);
    seen = 1'b0;
    repeat (10) @(negedge clock) if (node_ao_idx_ff === 3'h1 && node_ao_value_ff === 16'h2EE0) seen = 1'b1;
    chk("node_ao", 16'h0001, {15'h0, seen});
    for (int i = 0; i < 16; i++) io(on, on, on, 16'(i), 16'h0001, no);
    chk("func_all", 16'h00FF, {8'h0, func_active_ff});
    io(on, on, on, 16'h0000, 16'h0000, no); chk("cmd_off", 16'h00FE, {8'h0, func_active_ff});
    io(on, on, on, 16'h0008, 16'h0000, no); chk("use_off", 16'h00FF, {8'h0, func_active_ff});
    io(on, no, on, 16'h0004, 16'h0000, no); chk("pin_rd4", 16'h0000, {15'h0, rd[0]});
    io(on, no, on, 16'h0000, 16'h0000, no); chk("pin_rd0", 16'h0001, {15'h0, rd[0]});
    sw_alarm_reset = 1'b1;
    repeat (3) @(negedge clock);
    chk("alarm_sw", 16'h0001, {15'h0, alarm_reset_ff});
    sw_alarm_reset = 1'b0;
    hw_alarm_reset = 1'b1;
    repeat (6) @(negedge clock);
    chk("alarm_hw", 16'h0001, {15'h0, alarm_reset_ff});
    hw_alarm_reset = 1'b0;
    repeat (6) @(negedge clock);
    chk("alarm_off", 16'h0000, {15'h0, alarm_reset_ff});
    io(on, on, on, 16'h0010, 16'h0001, no);
    io(on, no, no, 16'h0041, 16'h0000, no); chk("status", 16'h01FF, rd);
    io(on, no, no, 16'h0050, 16'h0000, no); chk("node_ai", 16'((32'h0FFF * 32'h61A8) >> 12), rd);
    chk("ai_sel", 16'h0000, {13'h0, node_ai_sel_ff});
    // Both ports sit at 19200: one tick every 325 cycles
    n = 0; do @(negedge clock); while (mb_baud_tick_ff !== 1'b1);
    do begin @(negedge clock); n++; end while (mb_baud_tick_ff !== 1'b1 && n < 999);
    chk("mb_tick", 16'h0145, 16'(n));
    n = 0; do @(negedge clock); while (svc_baud_tick_ff !== 1'b1);
    do begin @(negedge clock); n++; end while (svc_baud_tick_ff !== 1'b1 && n < 999);
    chk("svc_tick", 16'h0145, 16'(n));
    conclude();
  end
endmodule // modbus_slave_port_control_tb
`default_nettype wire
